// file: dvi_pkg.sv
package dvi_pkg;

	// ---------------------------------------------------------------
	// widths and iteration counts
	// ---------------------------------------------------------------
	localparam int WORD_W      = 32;              // one data register
	localparam int HALF_W      = 16;              // half register
	localparam int PAIR_IDX_W  = 2;               // selects an odd:even pair
	localparam int REG_IDX_W   = 3;               // data register number
	localparam int CNT_W       = 6;               // iteration counter width
	localparam logic [CNT_W-1:0] ITER_FULL = 6'h20; // 32 iterations
	localparam logic [CNT_W-1:0] ITER_HALF = 6'h10; // 16 iterations
	localparam logic ODD_BIT   = 1'b1;            // low index bit, odd reg
	localparam logic EVEN_BIT  = 1'b0;            // low index bit, even reg
	localparam logic [HALF_W-1:0] HALF_ZERO = 16'h0000;

	// ---------------------------------------------------------------
	// operand width modes
	// ---------------------------------------------------------------
	typedef enum logic [1:0]
	{
		DVI_W32    = 2'h0,   // 32/32, full words
		DVI_W16_LO = 2'h1,   // 16-bit results in low halves
		DVI_W16_HI = 2'h2    // remainder in high half (alt placement)
	} dvi_mode_e;

	// ---------------------------------------------------------------
	// sequencer states, one-hot
	// ---------------------------------------------------------------
	typedef enum logic [2:0]
	{
		DVI_IDLE = 3'b001,
		DVI_RUN  = 3'b010,
		DVI_DONE = 3'b100
	} dvi_state_e;

	// operands loaded before the first iteration
	typedef struct packed
	{
		logic [WORD_W-1:0]     part;    // upper half of dividend
		logic [WORD_W-1:0]     quot;    // lower half of dividend
		logic [WORD_W-1:0]     negdiv;  // divisor, already negated
		logic [PAIR_IDX_W-1:0] pair;    // odd:even pair in use
		dvi_mode_e             mode;    // result width
	} dvi_load_s;

	// results presented after each iteration
	typedef struct packed
	{
		logic [WORD_W-1:0]    quot;     // quotient accumulation view
		logic [WORD_W-1:0]    rem;      // selected remainder view
		logic [REG_IDX_W-1:0] rem_idx;  // register that holds it
		logic                 trial_n;  // trial subtraction failed
		logic                 ovf;      // divide overflow seen
	} dvi_result_s;

endpackage

// file: dvi_step.sv
`timescale 1ns/1ps

// one divide-iterate step, purely combinational
module dvi_step
	import dvi_pkg::*;
(
	// current operands
	input  wire logic [WORD_W-1:0] cur_hi,
	input  wire logic [WORD_W-1:0] cur_lo,
	input  wire logic [WORD_W-1:0] negdiv,
	// step results
	output logic      [WORD_W-1:0] shifted_hi,
	output logic      [WORD_W-1:0] sum_hi,
	output logic      [WORD_W-1:0] next_lo,
	output logic                   trial_n
);

	// ---------------------------------------------------------------
	// shift pair left, add negated divisor to the upper half
	// ---------------------------------------------------------------
	logic [WORD_W+1:0] sum_x;   // two guard bits keep the carry-out
	logic              qbit;    // quotient bit of this step

	always_comb
	begin
		// divisor msb lines up with dividend msb; the bit shifted out
		// of the upper half is kept as a 33rd bit of the trial value
		shifted_hi = {cur_hi[WORD_W-2:0], cur_lo[WORD_W-1]};
		sum_x      = {1'b0, cur_hi[WORD_W-1], shifted_hi}
		           + {2'b01, negdiv};
		// carry into bit 33 means the shifted value was >= divisor
		qbit       = sum_x[WORD_W+1];
		sum_hi     = sum_x[WORD_W-1:0];
		next_lo    = {cur_lo[WORD_W-2:0], qbit};
		trial_n    = ~qbit;
	end

endmodule

// file: dvi_core.sv
`timescale 1ns/1ps

// Function
// (RL1) software keeps upper dividend below divisor
// (RL2) partial remainder odd, previous remainder even
// (RL3) first iteration never reads previous remainder
// (RL4) last flag picks remainder register
// (RL5) dividend is partial:quotient register pair
// (RL6) 32 by 32 ends after 32 iterations
// (RL7) 16-bit quotient low, upper half zero
// (RL8) 16-bit remainder one half, other zero
// (RL9) software issues exactly the alignment shift count
// (RL10) divisor msb aligned with dividend msb
// (RL11) software issues 16 iterations for halves
// (RL12) on overflow software widens or changes method
// (RL13) software negates divisor before first iteration
// (RL14) conditional field picks source by flag
// (RL15) shift, add, flag from sign, insert bit
module dvi_core
	import dvi_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rstn,
	// operand load
	input  wire logic        load_valid,
	input  wire dvi_load_s   load_data,
	// iteration issue
	input  wire logic        iter_valid,
	input  wire logic        iter_cond,
	// results
	output logic             busy,
	output logic             done,
	output dvi_result_s      result,
	output logic [REG_IDX_W-1:0] part_idx,
	output logic [REG_IDX_W-1:0] prev_idx
);

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	dvi_state_e          state_q, state_d;      // sequencer
	logic [WORD_W-1:0]   part_q, part_d;        // partial remainder reg
	logic [WORD_W-1:0]   prev_q, prev_d;        // previous remainder reg
	logic [WORD_W-1:0]   quot_q, quot_d;        // quotient accum reg
	logic [WORD_W-1:0]   ndiv_q, ndiv_d;        // negated divisor reg
	logic [PAIR_IDX_W-1:0] pair_q, pair_d;      // selected pair
	dvi_mode_e           mode_q, mode_d;        // result width
	logic [CNT_W-1:0]    cnt_q, cnt_d;          // iterations done
	logic                n_q, n_d;              // trial flag
	logic                ovf_q, ovf_d;          // overflow seen
	logic                done_q, done_d;        // one-cycle done pulse
	dvi_result_s         res_q, res_d;          // registered outputs

	// step wiring
	logic [WORD_W-1:0]   cur_hi;                // chosen dividend source
	logic [WORD_W-1:0]   sh_hi;                 // restored shifted value
	logic [WORD_W-1:0]   sum_hi;                // trial sum
	logic [WORD_W-1:0]   nxt_lo;                // quotient after step
	logic                step_n;                // trial failed

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	// iterations needed for a width mode
	function automatic logic [CNT_W-1:0] iters_for(input dvi_mode_e m);
		iters_for = (m == DVI_W32) ? ITER_FULL : ITER_HALF;
	endfunction

	// mask a 32-bit value to the half that the mode keeps
	function automatic logic [WORD_W-1:0] half_view(
		input dvi_mode_e   m,
		input logic        hi_half,
		input logic [WORD_W-1:0] v);
		if (m == DVI_W32)
			half_view = v;
		else if (hi_half)
			half_view = {v[WORD_W-1:HALF_W], HALF_ZERO};
		else
			half_view = {HALF_ZERO, v[HALF_W-1:0]};
	endfunction

	// ---------------------------------------------------------------
	// source selection and one iteration
	// ---------------------------------------------------------------
	// previous reg is only looked at when the conditional field is
	// given, so it may hold junk on the first step
	always_comb
	begin
		if (iter_cond && n_q)                       // RL14 RL3
			cur_hi = prev_q;
		else
			cur_hi = part_q;
	end

	dvi_step u_step
	(
		.cur_hi     (cur_hi),                       // RL5
		.cur_lo     (quot_q),
		.negdiv     (ndiv_q),                       // RL10
		.shifted_hi (sh_hi),
		.sum_hi     (sum_hi),
		.next_lo    (nxt_lo),
		.trial_n    (step_n)
	);

	// ---------------------------------------------------------------
	// next-state logic
	// ---------------------------------------------------------------
	always_comb
	begin
		state_d = state_q;
		part_d  = part_q;
		prev_d  = prev_q;
		quot_d  = quot_q;
		ndiv_d  = ndiv_q;
		pair_d  = pair_q;
		mode_d  = mode_q;
		cnt_d   = cnt_q;
		n_d     = n_q;
		ovf_d   = ovf_q;
		done_d  = 1'b0;
		case (state_q)
			DVI_IDLE, DVI_DONE:
			begin
				if (load_valid)
				begin
					// fresh operands; previous reg left as it is
					part_d  = load_data.part;
					quot_d  = load_data.quot;
					ndiv_d  = load_data.negdiv;
					pair_d  = load_data.pair;
					mode_d  = load_data.mode;
					cnt_d   = '0;
					n_d     = 1'b0;
					// upper half not below divisor: quotient won't fit
					ovf_d   = (load_data.part >= (-load_data.negdiv));
					state_d = DVI_RUN;
				end
			end
			DVI_RUN:
			begin
				if (iter_valid)
				begin
					prev_d = sh_hi;                  // RL15
					part_d = sum_hi;                 // RL15
					quot_d = nxt_lo;                 // RL15
					n_d    = step_n;                 // RL15
					cnt_d  = cnt_q + 6'h01;
					if (cnt_q + 6'h01 == iters_for(mode_q)) // RL6
					begin
						done_d  = 1'b1;
						state_d = DVI_DONE;
					end
				end
			end
			default:
			begin
				state_d = DVI_IDLE;
			end
		endcase
	end

	// ---------------------------------------------------------------
	// result views, registered
	// ---------------------------------------------------------------
	// the alternate 16-bit placement leaves the remainder high
	always_comb
	begin
		res_d.trial_n = n_d;
		res_d.ovf     = ovf_d;
		res_d.quot    = half_view(mode_d, 1'b0, quot_d);          // RL7
		if (n_d)                                                  // RL4
		begin
			res_d.rem     = half_view(mode_d, mode_d == DVI_W16_HI,
				prev_d);                                          // RL8
			res_d.rem_idx = {pair_d, EVEN_BIT};
		end
		else
		begin
			res_d.rem     = half_view(mode_d, mode_d == DVI_W16_HI,
				part_d);                                          // RL8
			res_d.rem_idx = {pair_d, ODD_BIT};
		end
	end

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			state_q <= DVI_IDLE;
			part_q  <= '0;
			prev_q  <= '0;
			quot_q  <= '0;
			ndiv_q  <= '0;
			pair_q  <= '0;
			mode_q  <= DVI_W32;
			cnt_q   <= '0;
			n_q     <= 1'b0;
			ovf_q   <= 1'b0;
			done_q  <= 1'b0;
			res_q   <= '0;
		end
		else
		begin
			state_q <= state_d;
			part_q  <= part_d;
			prev_q  <= prev_d;
			quot_q  <= quot_d;
			ndiv_q  <= ndiv_d;
			pair_q  <= pair_d;
			mode_q  <= mode_d;
			cnt_q   <= cnt_d;
			n_q     <= n_d;
			ovf_q   <= ovf_d;
			done_q  <= done_d;
			res_q   <= res_d;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign busy     = (state_q == DVI_RUN);
	assign done     = done_q;
	assign result   = res_q;
	assign part_idx = {pair_q, ODD_BIT};                          // RL2
	assign prev_idx = {pair_q, EVEN_BIT};                         // RL2

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	a_pair_odd_even: assert property (part_idx[0] && !prev_idx[0]
		&& part_idx[REG_IDX_W-1:1] == prev_idx[REG_IDX_W-1:1]) // RL2
		else $error("pair indices not odd:even");

	a_first_no_prev: assert property ((busy && iter_valid && cnt_q == '0
		&& !iter_cond) |=> prev_q == {$past(part_q[WORD_W-2:0]),
		$past(quot_q[WORD_W-1])})                                  // RL3
		else $error("first step read previous remainder");

	a_rem_select: assert property (done |-> (result.trial_n
		? result.rem_idx[0] == EVEN_BIT
		: result.rem_idx[0] == ODD_BIT))                           // RL4
		else $error("remainder register wrong for flag");

	a_qbit_insert: assert property ((busy && iter_valid) |=>
		quot_q[WORD_W-1:1] == $past(quot_q[WORD_W-2:0])
		&& quot_q[0] == !n_q)                                      // RL5
		else $error("quotient shift or bit insert wrong");

	a_count_full: assert property ((busy && iter_valid && mode_q == DVI_W32
		&& cnt_q == 6'h1f) |=> done && !busy)                      // RL6
		else $error("32-bit divide not done after 32 steps");

	a_no_early_done: assert property ((busy && iter_valid
		&& cnt_q < 6'h0f) |=> !done)                               // RL6
		else $error("done asserted too early");

	a_quot_half: assert property ((mode_q != DVI_W32 && !busy
		&& $past(busy)) |-> result.quot[WORD_W-1:HALF_W] == '0)    // RL7
		else $error("16-bit quotient upper half not zero");

	a_rem_half: assert property ((mode_q == DVI_W16_LO && done)
		|-> result.rem[WORD_W-1:HALF_W] == '0)                     // RL8
		else $error("16-bit remainder other half not zero");

	a_prev_restore: assert property ((busy && iter_valid) |=>
		prev_q == {$past(cur_hi[WORD_W-2:0]),
		$past(quot_q[WORD_W-1])})                                  // RL15
		else $error("previous remainder not the shifted value");

	a_cond_source: assert property ((busy && iter_valid && iter_cond
		&& n_q) |=> prev_q == {$past(prev_q[WORD_W-2:0]),
		$past(quot_q[WORD_W-1])})                                  // RL14
		else $error("conditional source not previous remainder");

	c_full_div: cover property (busy && iter_valid && mode_q == DVI_W32
		##1 done);
	c_half_div: cover property (mode_q == DVI_W16_HI && done);
	c_overflow: cover property (done && result.ovf);
	c_rem_prev: cover property (done && result.trial_n);

endmodule

// file: tb_top.sv
`timescale 1ns/1ps

module tb_top
	import dvi_pkg::*;
;
	// ---------------------------------------------------------------
	// expected outcome of one divide run
	// ---------------------------------------------------------------
	typedef struct packed
	{
		logic [WORD_W-1:0]    q;   // masked quotient
		logic [WORD_W-1:0]    r;   // masked remainder
		logic [REG_IDX_W-1:0] idx; // register holding remainder
		logic                 tn;  // last trial flag
		logic [CNT_W-1:0]     n;   // steps before done
		logic                 chk; // no overflow, values known
	} dvi_exp_s;

	logic             clk;         // 50 MHz
	logic             rstn;        // sync, active low
	logic             load_valid;  // operand load pulse
	dvi_load_s        load_data;   // operands
	logic             iter_valid;  // one step
	logic             iter_cond;   // conditional source field
	logic             busy;        // running
	logic             done;        // last step seen
	dvi_result_s      result;      // registered results
	logic [REG_IDX_W-1:0] part_idx; // odd register
	logic [REG_IDX_W-1:0] prev_idx; // even register
	int               num_errors;  // mismatches
	int               tests_run;   // comparisons
	dvi_exp_s         exp_q[$];    // notes from the driver
	dvi_exp_s         e_mon;       // note being compared
	logic [CNT_W-1:0] steps;       // steps taken since load
	logic [WORD_W-1:0] d;          // divisor under test
	logic [WORD_W-1:0] a;          // small dividend

	dvi_core u_dut
	(
		.clk        (clk),
		.rstn       (rstn),
		.load_valid (load_valid),
		.load_data  (load_data),
		.iter_valid (iter_valid),
		.iter_cond  (iter_cond),
		.busy       (busy),
		.done       (done),
		.result     (result),
		.part_idx   (part_idx),
		.prev_idx   (prev_idx)
	);

	// free running clock
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// ---------------------------------------------------------------
	// compare and report
	// ---------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		tests_run++;
		if (seen !== want)
		begin
			num_errors++;
			$display("BAD %0t got %h want %h", $time, seen, want);
		end
	endtask

	task automatic print_verdict();
		$display("errors %0d compares %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// ---------------------------------------------------------------
	// monitor: counts taken steps, compares on each done pulse
	// ---------------------------------------------------------------
	always @(posedge clk)
	begin
		// a load while busy must not restart the count
		if (!rstn || (load_valid && !busy))
			steps <= '0;
		else if (iter_valid && busy)
			steps <= steps + 6'h01;
		if (rstn && done)
		begin
			if (exp_q.size() == 0)
				check(32'h0000_0001, 32'h0000_0000);
			else
			begin
				e_mon = exp_q.pop_front();
				check(32'(steps), 32'(e_mon.n));
				if (e_mon.chk)
				begin
					check(result.quot, e_mon.q);
					check(result.rem, e_mon.r);
					check(32'(result.trial_n), 32'(e_mon.tn));
					check(32'(result.rem_idx), 32'(e_mon.idx));
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// driver: one load then a full run of steps
	// ---------------------------------------------------------------
	task automatic run_div(input logic [31:0] p, input logic [31:0] qd,
		input logic [31:0] dv, input logic [1:0] pr, input dvi_mode_e m);
		dvi_exp_s    e;
		logic [63:0] top;
		int          n;
		int          k;
		n = (m == DVI_W32) ? 32 : 16;
		top = {p, qd} >> (32 - n);
		e.chk = (dv != 0) && (p < dv);
		e.q = e.chk ? 32'(top / dv) : '0;
		e.r = e.chk ? 32'(top % dv) : '0;
		if (m != DVI_W32)
			e.q = e.q & 32'h0000_FFFF;
		if (m == DVI_W16_LO)
			e.r = e.r & 32'h0000_FFFF;
		e.tn = ~e.q[0];
		e.idx = {pr, ~e.tn};
		e.n = n[5:0];
		exp_q.push_back(e);
		load_valid <= 1'b1;
		load_data <= '{p, qd, -dv, pr, m};
		@(posedge clk);
		load_valid <= 1'b0;
		@(negedge clk);
		check(32'(result.ovf), 32'(!e.chk));
		check(32'(part_idx), 32'({pr, ODD_BIT}));
		check(32'(prev_idx), 32'({pr, EVEN_BIT}));
		@(posedge clk);
		for (k = 0; k < n; k++)
		begin
			// stray load in mid run must be ignored; one write per step
			load_valid <= (k == 3);
			iter_valid <= 1'b1;
			// first step leaves the even register unread
			iter_cond <= (k != 0);
			if (k == 3)
				load_data <= '{$urandom, $urandom, $urandom, pr, m};
			@(posedge clk);
		end
		iter_valid <= 1'b0;
		iter_cond <= 1'b0;
		k = 0;
		do
		begin
			@(negedge clk);
			k++;
		end
		while (busy !== 1'b0 && k < 8);
		if (busy !== 1'b0)
		begin
			num_errors++;
			print_verdict();
		end
		@(posedge clk);
	endtask

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial
	begin
		rstn = 1'b0;
		load_valid = 1'b0;
		load_data = '0;
		iter_valid = 1'b0;
		iter_cond = 1'b0;
		num_errors = 0;
		tests_run = 0;
		void'($urandom(23992));
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		@(negedge clk);
		check(32'({busy, done, result.ovf}), 32'h0000_0000);
		@(posedge clk);
		// full width, any odd divisor; large ones make the trial
		// value carry out of the upper half
		for (int i = 0; i < 8; i++)
		begin
			d = $urandom | 32'h0000_0001;
			run_div($urandom % d, $urandom, d, 2'($urandom), DVI_W32);
		end
		run_div('0, 32'hFFFF_FFFF, 32'h0000_0001, 2'h0, DVI_W32);
		run_div(32'h7FFF_FFFE, 32'hFFFF_FFFF, 32'h7FFF_FFFF, 2'h3,
			DVI_W32);
		// top bit set in divisor: every trial needs the 33rd bit
		run_div(32'hFFFF_FFFE, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 2'h1,
			DVI_W32);
		// half width, both placements
		for (int i = 0; i < 4; i++)
		begin
			a = $urandom & 32'h0000_FFFF;
			d = ($urandom % 32'h0000_7FFF) + 32'h0000_0001;
			run_div('0, a << 16, d, 2'(i), DVI_W16_LO);
			run_div(a, '0, d << 16, 2'(i), DVI_W16_HI);
		end
		// overflow at load: upper half equal to divisor, zero divisor
		run_div(32'h0000_0005, '0, 32'h0000_0005, 2'h1, DVI_W32);
		run_div('0, 32'h0000_0007, '0, 2'h2, DVI_W16_LO);
		repeat (4) @(posedge clk);
		check(32'(exp_q.size()), 32'h0000_0000);
		print_verdict();
	end

endmodule
